// ===== core/pwc_timer.sv
// Purpose: 16-bit pulse width measurement timer channel with AXI4-Lite registers
// Assumes: trigger inputs are asynchronous; count tick is aclk divided by CNT_DIV
// Notes: irq outputs are one-cycle pulses; the wrap flag lives in the option register
`timescale 1ns/1ps
module pwc_timer #(
   parameter int CNT_DIV = 1
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [pwc_pkg::ADDR_BITS-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [pwc_pkg::ADDR_BITS-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // external pulse inputs
   input wire logic capture_trigger_input0,
   input wire logic capture_trigger_input1,
   // interrupt request pulses
   output logic capture_irq0,
   output logic capture_irq1,
   output logic wrap_irq
);
   // refuse prescaler settings that the divider counter cannot hold
   if (CNT_DIV < 1 || CNT_DIV > 65536) begin : g_bad_div
      $error("CNT_DIV out of range");
   end

   localparam int DIV_BITS = (CNT_DIV > 1) ? $clog2(CNT_DIV) : 1;
   localparam logic [DIV_BITS-1:0] DIV_LAST = DIV_BITS'(CNT_DIV - 1);

   // ==========================================================
   // edge detect on a synchronised level
   function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prev);
      logic rise;
      logic fall;
      rise = cur & ~prev;
      fall = ~cur & prev;
      case (pwc_pkg::pwc_edge_t'(sel))
         pwc_pkg::EDGE_RISE: edge_hit = rise;
         pwc_pkg::EDGE_FALL: edge_hit = fall;
         pwc_pkg::EDGE_BOTH: edge_hit = rise | fall;
         default: edge_hit = 1'b0;
      endcase
   endfunction

   // ==========================================================
   // state
   logic [1:0] sync1_ff, sync2_ff, prev_ff;
   pwc_pkg::pwc_ctrl_t ctrl_ff, nxt_ctrl;
   pwc_pkg::pwc_edge_sel_t edge_ff, nxt_edge;
   logic [7:0] opt_ff, nxt_opt;
   logic [15:0] cnt_ff, nxt_cnt, cap0_ff, nxt_cap0, cap1_ff, nxt_cap1;
   logic [DIV_BITS-1:0] div_ff, nxt_div;
   logic started_ff, nxt_started;
   pwc_pkg::pwc_irq_t irq_ff, nxt_irq;
   logic aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
   logic [pwc_pkg::ADDR_BITS-1:0] awaddr_ff, nxt_awaddr;
   logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
   logic wstrb0_ff, nxt_wstrb0;
   logic awready_ff, nxt_awready, wready_ff, nxt_wready, bvalid_ff, nxt_bvalid;
   logic arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
   logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;

   // ==========================================================
   // counter, capture and register logic
   always_comb begin
      logic active;
      logic tick;
      logic hit0;
      logic hit1;
      logic do_wr;
      logic wrap_set;
      logic wr_ok;
      active = 1'b0;
      tick = 1'b0;
      hit0 = 1'b0;
      hit1 = 1'b0;
      do_wr = 1'b0;
      wrap_set = 1'b0;
      wr_ok = 1'b0;
      nxt_ctrl = ctrl_ff;
      nxt_edge = edge_ff;
      nxt_opt = opt_ff;
      nxt_cnt = cnt_ff;
      nxt_cap0 = cap0_ff;
      nxt_cap1 = cap1_ff;
      nxt_div = div_ff;
      nxt_started = started_ff;
      nxt_irq = '0;
      nxt_aw_held = aw_held_ff;
      nxt_w_held = w_held_ff;
      nxt_awaddr = awaddr_ff;
      nxt_wdata = wdata_ff;
      nxt_wstrb0 = wstrb0_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;

      active = ctrl_ff.count_run_enable &&
               ctrl_ff.timer_mode_select == pwc_pkg::MODE_PULSE_WIDTH;
      tick = active && div_ff == DIV_LAST;
      // software leaves the unused input at no edge, so both hitting is not expected
      hit0 = active && edge_hit(edge_ff.edge0, sync2_ff[0], prev_ff[0]);
      hit1 = active && edge_hit(edge_ff.edge1, sync2_ff[1], prev_ff[1]);

      if (!active) begin
         // a stopped counter parks at max so the first tick lands on zero
         nxt_cnt = pwc_pkg::CNT_MAX;
         nxt_div = '0;
         nxt_started = 1'b0;
      end else if (hit0 || hit1) begin
         // a trigger before the first tick captures the parked max value
         if (hit0) begin
            nxt_cap0 = cnt_ff;
         end
         if (hit1) begin
            nxt_cap1 = cnt_ff;
         end
         nxt_cnt = pwc_pkg::CNT_ZERO;
         nxt_div = '0;
         nxt_started = 1'b1;
         nxt_irq.capture_irq0 = hit0;
         nxt_irq.capture_irq1 = hit1;
      end else if (tick) begin
         nxt_div = '0;
         nxt_cnt = 16'(cnt_ff + 16'h0001);
         nxt_started = 1'b1;
         if (cnt_ff == pwc_pkg::CNT_MAX && started_ff) begin
            wrap_set = 1'b1;
            nxt_irq.wrap_irq = 1'b1;
         end
      end else begin
         nxt_div = DIV_BITS'(div_ff + 1'b1);
      end

      // write channel: address and data are taken in either order
      if (s_axi_awvalid && awready_ff) begin
         nxt_aw_held = 1'b1;
         nxt_awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
         nxt_w_held = 1'b1;
         nxt_wdata = s_axi_wdata;
         nxt_wstrb0 = s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
      do_wr = aw_held_ff && w_held_ff && !bvalid_ff;
      if (do_wr) begin
         nxt_aw_held = 1'b0;
         nxt_w_held = 1'b0;
         nxt_bvalid = 1'b1;
         wr_ok = 1'b1;
         case (awaddr_ff)
            pwc_pkg::ADDR_CTRL: begin
               if (wstrb0_ff) begin
                  nxt_ctrl = pwc_pkg::pwc_ctrl_t'(wdata_ff[7:0]);
                  nxt_ctrl.unused = '0;
               end
            end
            pwc_pkg::ADDR_EDGE: begin
               if (wstrb0_ff) begin
                  nxt_edge = pwc_pkg::pwc_edge_sel_t'(wdata_ff[7:0]);
                  nxt_edge.unused = '0;
               end
            end
            pwc_pkg::ADDR_OPT: begin
               // the flag only clears from software; writing one does not set it
               if (wstrb0_ff && !wdata_ff[pwc_pkg::OPT_WRAP_BIT]) begin
                  nxt_opt[pwc_pkg::OPT_WRAP_BIT] = 1'b0;
               end
            end
            pwc_pkg::ADDR_CNT, pwc_pkg::ADDR_CAP0, pwc_pkg::ADDR_CAP1: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
         endcase
         nxt_bresp = wr_ok ? pwc_pkg::RESP_OKAY : pwc_pkg::RESP_SLVERR;
      end
      // a wrap in the same cycle as a clear wins
      if (wrap_set) begin
         nxt_opt[pwc_pkg::OPT_WRAP_BIT] = 1'b1;
      end
      nxt_awready = !nxt_aw_held && !nxt_bvalid;
      nxt_wready = !nxt_w_held && !nxt_bvalid;

      // read channel
      if (s_axi_rvalid && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
      if (s_axi_arvalid && arready_ff) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = pwc_pkg::RESP_OKAY;
         nxt_rdata = '0;
         case (s_axi_araddr)
            pwc_pkg::ADDR_CTRL: nxt_rdata[7:0] = ctrl_ff;
            pwc_pkg::ADDR_EDGE: nxt_rdata[7:0] = edge_ff;
            pwc_pkg::ADDR_OPT: nxt_rdata[7:0] = opt_ff;
            // stopped counter reads as zero, not its parked max
            pwc_pkg::ADDR_CNT: nxt_rdata[15:0] = active ? cnt_ff : pwc_pkg::CNT_ZERO;
            pwc_pkg::ADDR_CAP0: nxt_rdata[15:0] = cap0_ff;
            pwc_pkg::ADDR_CAP1: nxt_rdata[15:0] = cap1_ff;
            default: nxt_rresp = pwc_pkg::RESP_SLVERR;
         endcase
      end
      nxt_arready = !nxt_rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         prev_ff <= '0;
         ctrl_ff <= '0;
         edge_ff <= '0;
         opt_ff <= '0;
         cnt_ff <= pwc_pkg::CNT_MAX;
         cap0_ff <= pwc_pkg::CNT_ZERO;
         cap1_ff <= pwc_pkg::CNT_ZERO;
         div_ff <= '0;
         started_ff <= 1'b0;
         irq_ff <= '0;
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff <= '0;
         wstrb0_ff <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= pwc_pkg::RESP_OKAY;
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= pwc_pkg::RESP_OKAY;
      end else begin
         sync1_ff <= {capture_trigger_input1, capture_trigger_input0};
         sync2_ff <= sync1_ff;
         prev_ff <= sync2_ff;
         ctrl_ff <= nxt_ctrl;
         edge_ff <= nxt_edge;
         opt_ff <= nxt_opt;
         cnt_ff <= nxt_cnt;
         cap0_ff <= nxt_cap0;
         cap1_ff <= nxt_cap1;
         div_ff <= nxt_div;
         started_ff <= nxt_started;
         irq_ff <= nxt_irq;
         aw_held_ff <= nxt_aw_held;
         w_held_ff <= nxt_w_held;
         awaddr_ff <= nxt_awaddr;
         wdata_ff <= nxt_wdata;
         wstrb0_ff <= nxt_wstrb0;
         awready_ff <= nxt_awready;
         wready_ff <= nxt_wready;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         arready_ff <= nxt_arready;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   // ==========================================================
   // outputs
   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign capture_irq0 = irq_ff.capture_irq0;
   assign capture_irq1 = irq_ff.capture_irq1;
   assign wrap_irq = irq_ff.wrap_irq;
endmodule

// ===== core/pwc_pkg.sv
// Purpose: constants and types shared by the pulse width capture timer
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register
// Notes: register offsets are byte addresses
//
// Behaviour
// - mode select value 110 selects pulse width measurement
// - 16-bit counter increments on count ticks only after run enable is 1
// - valid edge copies count to its capture register, clears counter, pulses capture irq
// - past ffff the next tick pulses wrap irq, wraps to 0000, keeps counting
// - wrap sets option bit 0 flag, held until software clears it
// - write of option register with bit 0 zero clears the wrap flag
// - trigger just after run enable with slow count clock may capture ffff
package pwc_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_EDGE = 8'h04;
   localparam logic [7:0] ADDR_OPT = 8'h08;
   localparam logic [7:0] ADDR_CNT = 8'h0c;
   localparam logic [7:0] ADDR_CAP0 = 8'h10;
   localparam logic [7:0] ADDR_CAP1 = 8'h14;
   localparam int ADDR_BITS = 8;

   // ==========================================================
   // field positions and values
   localparam int CTRL_RUN_BIT = 7;
   localparam int CTRL_MODE_LSB = 0;
   localparam int EDGE0_LSB = 0;
   localparam int EDGE1_LSB = 2;
   localparam int OPT_WRAP_BIT = 0;
   localparam logic [2:0] MODE_PULSE_WIDTH = 3'h6;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      EDGE_NONE,
      EDGE_RISE,
      EDGE_FALL,
      EDGE_BOTH
   } pwc_edge_t;

   typedef struct packed {
      logic count_run_enable;
      logic [3:0] unused;
      logic [2:0] timer_mode_select;
   } pwc_ctrl_t;

   typedef struct packed {
      logic [3:0] unused;
      logic [1:0] edge1;
      logic [1:0] edge0;
   } pwc_edge_sel_t;

   typedef struct packed {
      logic capture_irq1;
      logic capture_irq0;
      logic wrap_irq;
   } pwc_irq_t;
endpackage

// ===== testbench/pwc_chk.sv
// Purpose: port assertions for the pulse width capture timer
// Assumes: sees the top ports only
// Notes: bound to every pwc_timer
`timescale 1ns/1ps
module pwc_chk (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pulses
   input wire logic capture_trigger_input0,
   input wire logic capture_irq0,
   input wire logic capture_irq1,
   input wire logic wrap_irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // sequences
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // ==========================================================
   // assertions
   cap0_pulse_a: assert property (capture_irq0 |=> !capture_irq0)
      else $error("capture 0 pulse too long");
   cap1_pulse_a: assert property (capture_irq1 |=> !capture_irq1)
      else $error("capture 1 pulse too long");
   // a capture needs a pin change in the synchroniser window
   cap0_cause_a: assert property (capture_irq0 |->
      $past(capture_trigger_input0) != $past(capture_trigger_input0, 6))
      else $error("capture 0 without pin change");
   wrap_pulse_a: assert property (wrap_irq |=> !wrap_irq [*8])
      else $error("wrap pulses too close");
   wr_answer_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   rd_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response late");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
endmodule

bind pwc_timer pwc_chk i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .capture_trigger_input0, .capture_irq0, .capture_irq1, .wrap_irq);

// ===== testbench/pwc_pulse_src.sv
// Purpose: pulse source standing on the trigger pins
// Assumes: the bench asks for one level change at a time
// Notes: pins are driven push-pull, never released
`timescale 1ns/1ps
module pwc_pulse_src (
   // clock
   input wire logic aclk,
   // trigger pins
   output logic pin0,
   output logic pin1
);
   initial begin
      pin0 = 1'b0;
      pin1 = 1'b0;
   end
   // ==========================================================
   // only the named pin moves, the other keeps its level
   task automatic flip(input int sel, input int gap);
      repeat (gap) @(posedge aclk);
      if (sel == 1) pin1 <= ~pin1;
      else pin0 <= ~pin0;
   endtask
endmodule

// ===== testbench/tb_pulse_width_capture_timer.sv
// Purpose: self-checking bench for the pulse width capture timer
// Assumes: one count tick per clock, fixed seed
// Notes: the first capture after enabling is not compared, it may hold ffff
`timescale 1ns/1ps
module tb_pulse_width_capture_timer;
   localparam int CDIV = 1;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, t0, t1, irq0, irq1, wirq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   int mismatches, checks_done, cyc, tcap, twrap, n0, n1, nwrap, tlast, wlast, k, e;
   pwc_timer #(.CNT_DIV(CDIV)) i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .capture_trigger_input0(t0), .capture_trigger_input1(t1), .capture_irq0(irq0),
      .capture_irq1(irq1), .wrap_irq(wirq));
   pwc_pulse_src i_src (.aclk(aclk), .pin0(t0), .pin1(t1));
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (irq0 || irq1) tcap <= cyc;
      if (irq0) n0 <= n0 + 1;
      if (irq1) n1 <= n1 + 1;
      if (wirq) nwrap <= nwrap + 1;
      if (wirq) twrap <= cyc;
   end
   // ==========================================================
   // reporting
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic fail(input string nm);
      mismatches++;
      $display("BAD %s exp answer got timeout", nm);
      end_sim();
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   // ==========================================================
   // bus master
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = pwc_pkg::RESP_OKAY);
      // one edge between calls so the previous release of bready is never overwritten in the same step
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      for (k = 0; k < 40; k++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (k == 40) fail("bvalid");
      chk("bresp", 32'(bresp), 32'(er));
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] x,
      input logic [1:0] er = pwc_pkg::RESP_OKAY);
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      for (k = 0; k < 40; k++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (k == 40) fail("rvalid");
      chk(nm, rdata, x);
      chk("rresp", 32'(rresp), 32'(er));
   endtask
   // one pin change; kind is the edge code in force, 0 when no capture may follow
   task automatic hit(input int sel, input int kind, input int gap, input logic [7:0] a);
      int c;
      int t;
      logic lvl;
      logic ok;
      lvl = sel ? t1 : t0;
      ok = kind == 3 || (kind == 1 && !lvl) || (kind == 2 && lvl);
      c = sel ? n1 : n0;
      i_src.flip(sel, gap);
      t = cyc;
      repeat (8) @(posedge aclk);
      chk("capture irq", (sel ? n1 : n0) - c, 32'(ok));
      // the width counts every wrap since the last capture as 10000 ticks
      if (ok && tlast >= 0) begin
         rc("capture", a, (t - tlast - 1) / CDIV - 65536 * (nwrap - wlast));
      end
      if (ok) begin
         tlast = t;
         wlast = nwrap;
      end
   endtask
   // ==========================================================
   // main sequence
   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata} = 48'h0;
      wstrb = 4'hf;
      void'($urandom(70399));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      for (e = 0; e < 6; e++) rc("reset value", 8'(4 * e), 0);
      rc("unmapped", 8'h20, 0, pwc_pkg::RESP_SLVERR);
      wr(8'h20, 32'h1, pwc_pkg::RESP_SLVERR);
      wr(pwc_pkg::ADDR_CAP0, 32'h1234);
      rc("cap0 kept", pwc_pkg::ADDR_CAP0, 0);
      $display("test reset done");
      wr(pwc_pkg::ADDR_EDGE, 32'h3);
      for (e = 0; e < 8; e++) begin
         wr(pwc_pkg::ADDR_CTRL, (e == 6) ? 32'h6 : 32'h80 | e);
         rc("ctrl", pwc_pkg::ADDR_CTRL, (e == 6) ? 32'h6 : 32'h80 | e);
         hit(0, 0, 5, pwc_pkg::ADDR_CAP0);
         rc("idle count", pwc_pkg::ADDR_CNT, 0);
      end
      $display("test modes done");
      wr(pwc_pkg::ADDR_CTRL, 32'h86);
      tlast = -1;
      for (e = 1; e < 4; e++) begin
         wr(pwc_pkg::ADDR_EDGE, e);
         for (int i = 0; i < 4; i++) hit(0, e, 30 + $urandom % 200, pwc_pkg::ADDR_CAP0);
      end
      wr(pwc_pkg::ADDR_EDGE, 32'h8);
      for (int i = 0; i < 4; i++) hit(1, 2, 30 + $urandom % 200, pwc_pkg::ADDR_CAP1);
      hit(0, 0, 40, pwc_pkg::ADDR_CAP0);
      $display("test capture done");
      e = nwrap;
      for (int i = 0; i < 70000 && nwrap == e; i++) @(posedge aclk);
      if (nwrap == e) fail("wrap_irq");
      chk("wrap distance", twrap - tcap, 65536);
      rc("flag set", pwc_pkg::ADDR_OPT, 1);
      wr(pwc_pkg::ADDR_OPT, 32'h1);
      rc("flag kept", pwc_pkg::ADDR_OPT, 1);
      wr(pwc_pkg::ADDR_OPT, 32'h0);
      rc("flag cleared", pwc_pkg::ADDR_OPT, 0);
      wr(pwc_pkg::ADDR_EDGE, 32'hc);
      hit(1, 3, 50, pwc_pkg::ADDR_CAP1);
      $display("test wrap done");
      end_sim();
   end
endmodule
